// file: rtl/chgst_pkg.sv
// Constants, field layouts and carrier types of the charger status block.
package chgst_pkg;
  localparam logic [7:0] CHGST_ADDR_STATE = 8'h08;
  localparam logic [7:0] CHGST_ADDR_FAULT = 8'h09;
  localparam logic [7:0] CHGST_ADDR_LOOP = 8'h0A;
  localparam logic [7:0] CHGST_ADDR_PARTINFO = 8'h0B;
  localparam int CHGST_REGRST_BIT = 7;
  localparam int CHGST_VLOOP_MASK_BIT = 1;
  localparam int CHGST_ILOOP_MASK_BIT = 0;
  localparam logic [1:0] CHGST_MASK_RESET = 2'h0;
  localparam logic CHGST_WDT_POR = 1'h1;
  localparam logic [2:0] CHGST_SRC_NONE = 3'h0;
  localparam logic [2:0] CHGST_SRC_USB = 3'h1;
  localparam logic [2:0] CHGST_SRC_ADAPTER = 3'h3;
  localparam logic [2:0] CHGST_SRC_BOOST = 3'h7;
  localparam logic [2:0] CHGST_TS_NORMAL = 3'h0;
  localparam logic [2:0] CHGST_TS_WARM = 3'h2;
  localparam logic [2:0] CHGST_TS_COOL = 3'h3;
  localparam logic [2:0] CHGST_TS_COLD = 3'h5;
  localparam logic [2:0] CHGST_TS_HOT = 3'h6;
  localparam int CHGST_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CHGST_PH_IDLE, CHGST_PH_PRE, CHGST_PH_FAST, CHGST_PH_DONE
  } chgst_phase_t;

  typedef enum logic [1:0] {
    CHGST_CF_OK, CHGST_CF_INPUT, CHGST_CF_THERMAL, CHGST_CF_TIMER
  } chgst_cfault_t;

  // Raw conditions from the analog loops and the charger sequencer.
  typedef struct packed {
    logic vbus_present;
    logic boost_mode;
    logic psel_high;
    chgst_phase_t phase;
    logic power_good;
    logic thermal_reg;
    logic bat_below_min_sys;
    logic boost_fault;
    chgst_cfault_t cfault;
    logic bat_ovp;
    logic [2:0] ts_zone;
    logic source_ok;
    logic in_vloop;
    logic in_iloop;
    logic sense_fault;
    logic topoff_counting;
    logic input_ovp;
  } chgst_cond_t;

  // Register access from the serial bus engine.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chgst_req_t;
endpackage

// file: rtl/chgst_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module chgst_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) begin
      $error("chgst_sync: WIDTH must be at least one");
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// file: rtl/chgst_regs.sv
// Charger status registers with interrupt masks and register reset.
`timescale 1ns/1ps
module chgst_regs
  import chgst_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire chgst_cond_t i_cond,
  input wire logic i_wdt_expired,
  input wire logic i_host_mode_ack,
  input wire chgst_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_host_irq_pulse,
  output logic o_safety_timer_reset,
  output logic o_regulate_via_bat_pin,
  output logic o_regrst_busy
);
  localparam int COND_W = $bits(chgst_cond_t);

  chgst_cond_t cond_s;
  logic [COND_W-1:0] cond_sync;
  logic [7:0] state_reg;
  logic [7:0] fault_reg;
  logic [7:0] loop_reg;
  logic [1:0] irq_mask;
  logic wdt_flag;
  logic regrst_pending;
  logic [15:0] prev_fields;
  logic [1:0] prev_loops;
  logic primed;
  logic [7:0] rdata;
  logic rvalid;

  chgst_sync #(
    .WIDTH(COND_W)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_cond),
    .o_sync(cond_sync)
  );
  assign cond_s = chgst_cond_t'(cond_sync);

  function automatic logic [2:0] src_code(input chgst_cond_t c);
    if (c.boost_mode) begin
      src_code = CHGST_SRC_BOOST;
    end else if (!c.vbus_present) begin
      src_code = CHGST_SRC_NONE;
    end else if (c.psel_high) begin
      src_code = CHGST_SRC_USB;
    end else begin
      src_code = CHGST_SRC_ADAPTER;
    end
  endfunction

  function automatic logic [2:0] ts_code(input chgst_cond_t c);
    logic [2:0] z;
    z = c.ts_zone;
    if (z == CHGST_TS_COLD || z == CHGST_TS_HOT) begin
      ts_code = z;
    end else if (!c.boost_mode &&
                 (z == CHGST_TS_WARM || z == CHGST_TS_COOL)) begin
      ts_code = z;
    end else begin
      ts_code = CHGST_TS_NORMAL;
    end
  endfunction

  // Source type reflects only the detected source, never the current limit.
  wire [2:0] src_w = src_code(cond_s);
  wire [1:0] phase_w = cond_s.phase;
  wire vsys_w = cond_s.bat_below_min_sys;
  // Warm and cool collapse to normal while boosting.
  wire [2:0] ts_w = ts_code(cond_s);

  assign state_reg = {src_w, phase_w, cond_s.power_good,
                      cond_s.thermal_reg, vsys_w};
  assign fault_reg = {wdt_flag, cond_s.boost_fault, cond_s.cfault,
                      cond_s.bat_ovp, ts_w};
  assign loop_reg = {cond_s.source_ok, cond_s.in_vloop, cond_s.in_iloop,
                     cond_s.sense_fault, cond_s.topoff_counting,
                     cond_s.input_ovp, irq_mask};
  assign o_regulate_via_bat_pin = cond_s.sense_fault;

  wire wr_loop = i_req.wr && i_req.addr == CHGST_ADDR_LOOP;
  wire [1:0] wr_mask = i_req.wdata[CHGST_VLOOP_MASK_BIT:CHGST_ILOOP_MASK_BIT];
  wire wr_rst = i_req.wr && i_req.addr == CHGST_ADDR_PARTINFO &&
                i_req.wdata[CHGST_REGRST_BIT];

  // Watchdog flag is set by expiry; the set wins over a host-mode clear.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wdt_flag <= CHGST_WDT_POR;
    end else if (i_wdt_expired) begin
      wdt_flag <= 1'b1;
    end else if (i_host_mode_ack) begin
      wdt_flag <= 1'b0;
    end
  end

  // Only the two mask bits accept writes; status bits are live values.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_mask <= CHGST_MASK_RESET;
    end else if (regrst_pending) begin
      irq_mask <= CHGST_MASK_RESET;
    end else if (wr_loop) begin
      irq_mask <= wr_mask;
    end
  end

  // Reset request holds for one cycle, then the bit reads back as zero.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      regrst_pending <= 1'b0;
    end else begin
      regrst_pending <= wr_rst && !regrst_pending;
    end
  end
  assign o_regrst_busy = regrst_pending;
  assign o_safety_timer_reset = regrst_pending;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= i_req.rd;
      case (i_req.addr)
        CHGST_ADDR_STATE: rdata <= state_reg;
        CHGST_ADDR_FAULT: rdata <= fault_reg;
        CHGST_ADDR_LOOP: rdata <= loop_reg;
        default: rdata <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata;
  assign o_rvalid = rvalid;

  // Interrupt on any state or fault register change; loop entries are gated by their masks.
  wire [15:0] cur_fields = {state_reg, fault_reg};
  wire [1:0] cur_loops = {cond_s.in_vloop, cond_s.in_iloop};
  wire field_chg = cur_fields != prev_fields;
  wire vloop_evt = cur_loops[1] && !prev_loops[1] &&
                   !irq_mask[CHGST_VLOOP_MASK_BIT];
  wire iloop_evt = cur_loops[0] && !prev_loops[0] &&
                   !irq_mask[CHGST_ILOOP_MASK_BIT];

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_fields <= 16'h0000;
      prev_loops <= 2'h0;
      primed <= 1'b0;
      o_host_irq_pulse <= 1'b0;
    end else begin
      prev_fields <= cur_fields;
      prev_loops <= cur_loops;
      primed <= 1'b1;
      o_host_irq_pulse <= primed &&
                          (field_chg || vloop_evt || iloop_evt);
    end
  end

  property p_mask_default;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      regrst_pending |=> irq_mask == CHGST_MASK_RESET;
  endproperty
  a_mask_default: assert property (p_mask_default)
    else $error("masks not restored after register reset");

  property p_regrst_clears;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      regrst_pending |=> !regrst_pending;
  endproperty
  a_regrst_clears: assert property (p_regrst_clears)
    else $error("register reset bit did not clear");

  property p_boost_ts;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      cond_s.boost_mode |-> ts_w != CHGST_TS_WARM && ts_w != CHGST_TS_COOL;
  endproperty
  a_boost_ts: assert property (p_boost_ts)
    else $error("warm or cool reported in boost mode");

  property p_boost_src;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      cond_s.boost_mode |-> state_reg[7:5] == CHGST_SRC_BOOST;
  endproperty
  a_boost_src: assert property (p_boost_src)
    else $error("boost source code wrong");

  property p_vmask;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (irq_mask[CHGST_VLOOP_MASK_BIT] && $rose(cond_s.in_vloop) &&
       $stable(cur_fields) && !iloop_evt) |=> !o_host_irq_pulse;
  endproperty
  a_vmask: assert property (p_vmask)
    else $error("masked voltage loop raised interrupt");

  property p_imask;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (irq_mask[CHGST_ILOOP_MASK_BIT] && $rose(cond_s.in_iloop) &&
       $stable(cur_fields) && !vloop_evt) |=> !o_host_irq_pulse;
  endproperty
  a_imask: assert property (p_imask)
    else $error("masked current loop raised interrupt");

  property p_irq_on_change;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (primed && field_chg) |=> o_host_irq_pulse;
  endproperty
  a_irq_on_change: assert property (p_irq_on_change)
    else $error("field change gave no interrupt");

  property p_wdt_set;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      i_wdt_expired |=> fault_reg[7];
  endproperty
  a_wdt_set: assert property (p_wdt_set)
    else $error("watchdog flag not set");

  property p_read_ro;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_req.rd && i_req.addr == CHGST_ADDR_FAULT) |=>
        o_rvalid && o_rdata == $past(fault_reg);
  endproperty
  a_read_ro: assert property (p_read_ro)
    else $error("read did not return live fault flags");

  property p_wdt_clear;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_host_mode_ack && !i_wdt_expired) |=> !fault_reg[7];
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog flag not cleared by host mode");

  property p_mask_write;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (wr_loop && !regrst_pending) |=> irq_mask == $past(wr_mask);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write did not land");

  property p_rvalid_on;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      i_req.rd |=> o_rvalid;
  endproperty
  a_rvalid_on: assert property (p_rvalid_on)
    else $error("read gave no valid strobe");

  property p_rvalid_off;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      !i_req.rd |=> !o_rvalid;
  endproperty
  a_rvalid_off: assert property (p_rvalid_off)
    else $error("valid strobe without a read");

  property p_read_state;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_req.rd && i_req.addr == CHGST_ADDR_STATE) |=>
        o_rdata == $past(state_reg);
  endproperty
  a_read_state: assert property (p_read_state)
    else $error("read did not return live state flags");

  property p_read_loop;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_req.rd && i_req.addr == CHGST_ADDR_LOOP) |=>
        o_rdata == $past(loop_reg);
  endproperty
  a_read_loop: assert property (p_read_loop)
    else $error("read did not return live loop flags");

  property p_read_unmapped;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_req.rd && i_req.addr != CHGST_ADDR_STATE &&
       i_req.addr != CHGST_ADDR_FAULT && i_req.addr != CHGST_ADDR_LOOP) |=>
        o_rdata == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read returned nonzero data");

  property p_timer_reset;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (wr_rst && !regrst_pending) |=> o_safety_timer_reset && o_regrst_busy;
  endproperty
  a_timer_reset: assert property (p_timer_reset)
    else $error("register reset did not reset the safety timer");

  property p_ts_buck;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (!cond_s.boost_mode && (cond_s.ts_zone == CHGST_TS_WARM ||
                              cond_s.ts_zone == CHGST_TS_COOL)) |->
        ts_w == cond_s.ts_zone;
  endproperty
  a_ts_buck: assert property (p_ts_buck)
    else $error("warm or cool lost in buck mode");

  property p_src_none;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (!cond_s.boost_mode && !cond_s.vbus_present) |->
        state_reg[7:5] == CHGST_SRC_NONE;
  endproperty
  a_src_none: assert property (p_src_none)
    else $error("source code wrong with no input");

  // A level that merely holds must stay silent, or the host is flooded.
  property p_irq_quiet;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      ($stable(cur_fields) && !$rose(cond_s.in_vloop) &&
       !$rose(cond_s.in_iloop) && primed) |=> !o_host_irq_pulse;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt pulse without a change");
endmodule

// file: test/chgst_host.sv
// Host model that issues register reads and writes on the request port.
`timescale 1ns/1ps
module chgst_host
  import chgst_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output chgst_req_t o_req
);
  initial begin
    o_req = '0;
  end

  // Idle address and data show the inverse of the last value on purpose.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d = i_rdata;
      end else begin
        @(posedge i_sys_clk);
      end
    end
  endtask
endmodule

// file: test/tb_chgst_regs.sv
// Self-checking bench for the charger status registers.
`timescale 1ns/1ps
module tb_chgst_regs
  import chgst_pkg::*;
;
  logic i_sys_clk;
  logic i_arst_n;
  chgst_cond_t cond;
  logic wdt_exp;
  logic host_ack;
  chgst_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic irq;
  logic tmr_rst;
  logic bat_pin;
  logic busy;
  int fail_count;
  int check_count;
  int irqs;
  int busys;

  chgst_regs u_chgst_regs (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_cond(cond), .i_wdt_expired(wdt_exp), .i_host_mode_ack(host_ack),
    .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_host_irq_pulse(irq), .o_safety_timer_reset(tmr_rst),
    .o_regulate_via_bat_pin(bat_pin), .o_regrst_busy(busy));
  chgst_host u_chgst_host (.i_sys_clk(i_sys_clk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_req(req));

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    if (irq === 1'b1) irqs++;
    if (busy === 1'b1 && tmr_rst === 1'b1) busys++;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_chgst_host.rd_reg(a, d, ok);
    if (!ok) begin
      fail_count++;
      close_out();
    end
    chk($sformatf("reg %h", a), d, exp);
  endtask

  // Inputs pass a two-flop synchroniser, so give them time to land.
  task automatic put(chgst_cond_t v);
    @(posedge i_sys_clk);
    cond <= v;
    repeat (6) @(posedge i_sys_clk);
  endtask

  task automatic t_src;
    logic [2:0] vin [4] = '{3'b000, 3'b101, 3'b100, 3'b111};
    logic [2:0] ex [4] = '{CHGST_SRC_NONE, CHGST_SRC_USB,
                           CHGST_SRC_ADAPTER, CHGST_SRC_BOOST};
    chgst_cond_t c;
    for (int i = 0; i < 4; i++) begin
      c = '0;
      {c.vbus_present, c.boost_mode, c.psel_high} = vin[i];
      put(c);
      rd(CHGST_ADDR_STATE, {ex[i], 5'h00});
    end
    $display("source test done");
  endtask

  task automatic t_state;
    chgst_cond_t c;
    logic [1:0] p;
    int n;
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      c = '0;
      c.phase = chgst_phase_t'(p);
      {c.thermal_reg, c.power_good, c.bat_below_min_sys} = {p, ~p[0]};
      n = irqs;
      put(c);
      chk("irq count", 8'(irqs - n), 8'h01);
      e = {3'h0, p, p[0], p[1], ~p[0]};
      rd(CHGST_ADDR_STATE, e);
    end
    $display("state test done");
  endtask

  task automatic t_fault;
    logic [2:0] ts [6] = '{CHGST_TS_NORMAL, CHGST_TS_WARM, CHGST_TS_COOL,
                           CHGST_TS_COLD, CHGST_TS_HOT, CHGST_TS_WARM};
    // The last case is warm while boosting, which must read as normal.
    logic [2:0] tx [6] = '{CHGST_TS_NORMAL, CHGST_TS_WARM, CHGST_TS_COOL,
                           CHGST_TS_COLD, CHGST_TS_HOT, CHGST_TS_NORMAL};
    chgst_cond_t c;
    logic [1:0] k;
    logic [7:0] e;
    for (int i = 0; i < 6; i++) begin
      k = 2'(i);
      c = '0;
      c.cfault = chgst_cfault_t'(k);
      {c.bat_ovp, c.boost_fault} = k;
      c.ts_zone = ts[i];
      c.boost_mode = (i >= 4);
      put(c);
      e = {1'b1, k[0], k, k[1], tx[i]};
      rd(CHGST_ADDR_FAULT, e);
    end
    put('0);
    @(posedge i_sys_clk);
    host_ack <= 1'b1;
    @(posedge i_sys_clk);
    host_ack <= 1'b0;
    rd(CHGST_ADDR_FAULT, 8'h00);
    @(posedge i_sys_clk);
    wdt_exp <= 1'b1;
    @(posedge i_sys_clk);
    wdt_exp <= 1'b0;
    rd(CHGST_ADDR_FAULT, 8'h80);
    $display("fault test done");
  endtask

  task automatic t_loop;
    chgst_cond_t c;
    c = '0;
    {c.source_ok, c.sense_fault, c.topoff_counting, c.input_ovp} = 4'hF;
    put(c);
    rd(CHGST_ADDR_LOOP, 8'h9C);
    chk("bat pin", {7'h00, bat_pin}, 8'h01);
    put('0);
    rd(CHGST_ADDR_LOOP, 8'h00);
    chk("bat pin", {7'h00, bat_pin}, 8'h00);
    $display("loop test done");
  endtask

  task automatic t_mask;
    chgst_cond_t c;
    int n;
    logic [7:0] m;
    for (int b = 0; b < 2; b++) begin
      c = '0;
      {c.in_vloop, c.in_iloop} = (b == 0) ? 2'b10 : 2'b01;
      // Each loop is masked by its own bit only, so a swap shows up.
      m = (b == 0) ? 8'h02 : 8'h01;
      u_chgst_host.wr_reg(CHGST_ADDR_LOOP, m);
      rd(CHGST_ADDR_LOOP, m);
      n = irqs;
      put(c);
      put('0);
      chk("masked irq", 8'(irqs - n), 8'h00);
      u_chgst_host.wr_reg(CHGST_ADDR_LOOP, m ^ 8'h03);
      n = irqs;
      put(c);
      chk("open irq", 8'(irqs - n), 8'h01);
      put('0);
    end
    u_chgst_host.wr_reg(CHGST_ADDR_STATE, 8'hFF);
    u_chgst_host.wr_reg(CHGST_ADDR_FAULT, 8'h7F);
    u_chgst_host.wr_reg(CHGST_ADDR_LOOP, 8'hFC);
    rd(CHGST_ADDR_STATE, 8'h00);
    rd(CHGST_ADDR_FAULT, 8'h80);
    rd(CHGST_ADDR_LOOP, 8'h00);
    $display("mask test done");
  endtask

  task automatic t_regrst;
    u_chgst_host.wr_reg(CHGST_ADDR_LOOP, 8'h03);
    busys = 0;
    u_chgst_host.wr_reg(CHGST_ADDR_PARTINFO, 8'h80);
    repeat (3) @(posedge i_sys_clk);
    chk("reset pulse", 8'(busys), 8'h01);
    rd(CHGST_ADDR_LOOP, 8'h00);
    rd(CHGST_ADDR_PARTINFO, 8'h00);
    $display("register reset test done");
  endtask

  // A reset in mid-run brings back the power-on flag and open masks.
  task automatic t_reset;
    int n;
    u_chgst_host.wr_reg(CHGST_ADDR_LOOP, 8'h03);
    @(posedge i_sys_clk);
    host_ack <= 1'b1;
    @(posedge i_sys_clk);
    host_ack <= 1'b0;
    rd(CHGST_ADDR_FAULT, 8'h00);
    n = irqs;
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk("irq after reset", 8'(irqs - n), 8'h00);
    rd(CHGST_ADDR_FAULT, 8'h80);
    rd(CHGST_ADDR_LOOP, 8'h00);
    $display("mid-run reset test done");
  endtask

  initial begin
    i_arst_n = 1'b0;
    cond = '0;
    wdt_exp = 1'b0;
    host_ack = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    rd(CHGST_ADDR_FAULT, 8'h80);
    rd(CHGST_ADDR_LOOP, 8'h00);
    t_src();
    t_state();
    t_fault();
    t_loop();
    t_mask();
    t_regrst();
    t_reset();
    close_out();
  end
endmodule
